// ---- asrc_pkg.sv ----
// Constants for the host-side controller of a 4096 x 1 asynchronous static RAM.
// Assumes a single 100 MHz clock; all pin timing is counted in whole cycles.
// Functional notes
// - Word index stable before select falls.
// - Strobe or select high while index changes.
// - Wait 500 us after power-up.
// - Read cycle no shorter than minimum.
// - Write strobe low long enough.
// - Select low long enough before write end.
package asrc_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned POWERUP_US      = 500;
  localparam int unsigned ACCESS_NS       = 70;
  localparam int unsigned READ_CYCLE_NS   = 70;
  localparam int unsigned WRITE_PULSE_NS  = 40;
  localparam int unsigned SEL_TO_END_NS   = 55;
  localparam int unsigned WRITE_RECOV_NS  = 15;
  localparam int unsigned DATA_HOLD_NS    = 10;
  // Least times round up to whole cycles
  localparam int unsigned POWERUP_CYC     = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC        = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPULSE_CYC      = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEL_END_CYC     = (SEL_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_RAW       = (WRITE_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_RAW        = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOV_CYC       = (RECOV_RAW > HOLD_RAW) ? RECOV_RAW : HOLD_RAW;
  localparam int unsigned WORDS           = 4096;
  localparam int unsigned IDX_W           = 12;
  localparam int unsigned CNT_W           = 16;

  typedef enum logic [2:0] {
    ASRC_WAIT_PWR = 3'b000,
    ASRC_IDLE     = 3'b001,
    ASRC_RD       = 3'b011,
    ASRC_WR_SEL   = 3'b010,
    ASRC_WR_PULSE = 3'b110,
    ASRC_RECOV    = 3'b111
  } asrc_state_e;
endpackage

// ---- asrc_ctrl.sv ----
// Host controller driving a 4096 x 1 asynchronous static RAM over its pins.
// Assumes the memory output is sampled as a synchronous input.
`timescale 1ns/10ps
`default_nettype none
module asrc_ctrl #(
  parameter int unsigned POWERUP_CYCLES = asrc_pkg::POWERUP_CYC
) (
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      req_valid_i,
  input  wire logic                      req_write_i,
  input  wire logic [asrc_pkg::IDX_W-1:0] req_index_i,
  input  wire logic                      req_data_i,
  output logic                           req_ready_o,
  output logic                           rsp_valid_o,
  output logic                           rsp_data_o,
  output logic                           mem_ready_o,
  output logic [asrc_pkg::IDX_W-1:0]     word_index_o,
  output logic                           sel_n_o,
  output logic                           wr_n_o,
  output logic                           din_o,
  input  wire logic                      dout_i,
  input  wire logic                      dout_oe_n_i
);
  import asrc_pkg::*;

  asrc_state_e              state_r;
  logic                     done;
  logic                     load;
  logic [CNT_W-1:0]         load_val;

  asrc_timer #(.W(CNT_W)) u_timer (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .load_i   (load),
    .value_i  (load_val),
    .count_o  (),
    .done_o   (done)
  );

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n - 1);
  endfunction

  assign req_ready_o = (state_r == ASRC_IDLE);
  assign mem_ready_o = (state_r != ASRC_WAIT_PWR);

  always_comb begin
    load     = 1'b0;
    load_val = '0;
    case (state_r)
      ASRC_IDLE: begin
        if (req_valid_i) begin
          load     = 1'b1;
          // Extra cycle: select is registered one clock after the index
          load_val = req_write_i ? cyc(SEL_END_CYC - WPULSE_CYC + 1) : cyc(ACCESS_CYC + 1);
        end
      end
      ASRC_WR_SEL: begin
        if (done) begin
          load     = 1'b1;
          load_val = cyc(WPULSE_CYC);
        end
      end
      ASRC_RD, ASRC_WR_PULSE: begin
        if (done) begin
          load     = 1'b1;
          load_val = cyc(RECOV_CYC);
        end
      end
      default: begin
        load     = 1'b0;
        load_val = '0;
      end
    endcase
  end

  // Power-up wait counter kept apart; it can exceed the short timer
  logic [19:0] pwr_cnt_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_cnt_r <= 20'h0_0000;
    end else if (state_r == ASRC_WAIT_PWR) begin
      pwr_cnt_r <= pwr_cnt_r + 20'h0_0001;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ASRC_WAIT_PWR;
    end else begin
      case (state_r)
        ASRC_WAIT_PWR: if (pwr_cnt_r >= 20'(POWERUP_CYCLES - 1)) state_r <= ASRC_IDLE;
        ASRC_IDLE:     if (req_valid_i) state_r <= req_write_i ? ASRC_WR_SEL : ASRC_RD;
        ASRC_RD:       if (done) state_r <= ASRC_RECOV;
        ASRC_WR_SEL:   if (done) state_r <= ASRC_WR_PULSE;
        ASRC_WR_PULSE: if (done) state_r <= ASRC_RECOV;
        ASRC_RECOV:    if (done) state_r <= ASRC_IDLE;
        default:       state_r <= ASRC_WAIT_PWR;
      endcase
    end
  end

  // Index and data latched at acceptance, stable through the whole access
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_index_o <= '0;
      din_o        <= 1'b0;
    end else if (state_r == ASRC_IDLE && req_valid_i) begin
      word_index_o <= req_index_i;
      din_o        <= req_data_i;
    end
  end

  // Select falls one cycle after the index settles; strobe only inside select
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_n_o <= 1'b1;
      wr_n_o  <= 1'b1;
    end else begin
      sel_n_o <= !(state_r == ASRC_RD || state_r == ASRC_WR_SEL ||
                   state_r == ASRC_WR_PULSE) ||
                 ((state_r == ASRC_RD || state_r == ASRC_WR_PULSE) && done);
      wr_n_o  <= !((state_r == ASRC_WR_SEL && done) ||
                   (state_r == ASRC_WR_PULSE && !done));
    end
  end

  // Read sampled at the end of the full access time, before deselect
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 1'b0;
    end else begin
      rsp_valid_o <= (state_r == ASRC_RD) && done;
      if ((state_r == ASRC_RD) && done) begin
        rsp_data_o <= dout_i;
      end
    end
  end

  // Index never moves while a select or strobe is active
  property p_index_stable;
    @(posedge mclk_i) disable iff (!resetn_i)
      (!sel_n_o || !wr_n_o) |-> $stable(word_index_o);
  endproperty
  a_index_stable: assert property (p_index_stable) else $error("Index moved during access");

  property p_strobe_in_select;
    @(posedge mclk_i) disable iff (!resetn_i)
      !wr_n_o |-> !sel_n_o;
  endproperty
  a_strobe_in_select: assert property (p_strobe_in_select) else $error("Strobe outside select");

  sequence s_wr_fall;
    $fell(wr_n_o);
  endsequence
  property p_wr_width;
    @(posedge mclk_i) disable iff (!resetn_i)
      s_wr_fall |-> !wr_n_o [*4] ##1 wr_n_o;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("Write pulse width wrong");

  property p_sel_before_end;
    @(posedge mclk_i) disable iff (!resetn_i)
      $rose(wr_n_o) |-> $past(sel_n_o, 6) == 1'b0;
  endproperty
  a_sel_before_end: assert property (p_sel_before_end) else $error("Select too short before write end");

  property p_read_len;
    @(posedge mclk_i) disable iff (!resetn_i)
      ($fell(sel_n_o) && wr_n_o && state_r == ASRC_RD) |-> !sel_n_o [*7] ##1 sel_n_o;
  endproperty
  a_read_len: assert property (p_read_len) else $error("Read cycle length wrong");

  property p_rsp_after_read;
    @(posedge mclk_i) disable iff (!resetn_i)
      rsp_valid_o |-> $past(!sel_n_o) && $past(wr_n_o);
  endproperty
  a_rsp_after_read: assert property (p_rsp_after_read) else $error("Response without read");

  property p_no_access_early;
    @(posedge mclk_i) disable iff (!resetn_i)
      !mem_ready_o |-> sel_n_o && wr_n_o;
  endproperty
  a_no_access_early: assert property (p_no_access_early) else $error("Access before power-up");

  property p_index_before_sel;
    @(posedge mclk_i) disable iff (!resetn_i)
      $fell(sel_n_o) |-> $stable(word_index_o);
  endproperty
  a_index_before_sel: assert property (p_index_before_sel) else $error("Index changed at select");

  property p_recovery;
    @(posedge mclk_i) disable iff (!resetn_i)
      $rose(sel_n_o) |-> sel_n_o [*2];
  endproperty
  a_recovery: assert property (p_recovery) else $error("Recovery too short");
endmodule
`default_nettype wire

// ---- asrc_timer.sv ----
// Loadable down-counter timing each pin phase.
// Assumes load and value are driven from the same clock.
`timescale 1ns/10ps
`default_nettype none
module asrc_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic      [W-1:0] count_o,
  output logic              done_o
);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= value_i;
    end else if (count_o != '0) begin
      count_o <= count_o - W'(1);
    end
  end

  // Done ignores load so the caller may reload on done without a loop
  assign done_o = (count_o == '0);
endmodule
`default_nettype wire

// ---- asrc_sram_model.sv ----
// Pin-level model of the 4096 x 1 static RAM behind the controller.
// Assumes zero-delay pins; a floating output shows the inverse of its last value.
`timescale 1ns/10ps
`default_nettype none
module asrc_sram_model (
  input  wire logic                       sel_n_i,
  input  wire logic                       wr_n_i,
  input  wire logic [asrc_pkg::IDX_W-1:0] word_index_i,
  input  wire logic                       din_i,
  output logic                            dout_o,
  output logic                            dout_oe_n_o,
  output logic                            standby_o
);
  import asrc_pkg::*;
  logic mem [WORDS];
  logic last_bit = 1'h0;
  assign standby_o = sel_n_i;
  always @* begin
    if (!sel_n_i && !wr_n_i) begin
      mem[word_index_i] = din_i;
    end
  end
  // Zero access time is the kindest grade; the host samples late anyway
  always @* begin
    if (!sel_n_i && wr_n_i) begin
      dout_o      = mem[word_index_i];
      dout_oe_n_o = 1'h0;
      last_bit    = dout_o;
    end else begin
      dout_o      = ~last_bit;
      dout_oe_n_o = 1'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb_async_static_ram_4k_by_1.sv ----
// Testbench for the host controller against the static RAM model.
// Assumes registered pins; the monitor sees each pin's settled value at every edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_async_static_ram_4k_by_1;
  import asrc_pkg::*;
  localparam int unsigned PWR = 20;
  logic             mclk_i = 1'h0;
  logic             resetn_i, req_valid_i, req_write_i, req_data_i;
  logic [IDX_W-1:0] req_index_i, word_index_o, idx_q;
  logic             req_ready_o, rsp_valid_o, rsp_data_o, mem_ready_o;
  logic             sel_n_o, wr_n_o, din_o, dout, dout_oe_n, sel_q, wr_q;
  int               failures = 0;
  int               cmp_count = 0;
  int               wlow = 0;
  int               slow = 0;
  always #5 mclk_i = ~mclk_i;
  asrc_ctrl #(.POWERUP_CYCLES(PWR)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_index_i(req_index_i),
    .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .mem_ready_o(mem_ready_o), .word_index_o(word_index_o),
    .sel_n_o(sel_n_o), .wr_n_o(wr_n_o), .din_o(din_o), .dout_i(dout),
    .dout_oe_n_i(dout_oe_n));
  asrc_sram_model mem_model (.sel_n_i(sel_n_o), .wr_n_i(wr_n_o), .word_index_i(word_index_o),
    .din_i(din_o), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .standby_o());
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Holds the request until the edge that takes it
  task automatic issue(input logic wr, input logic [IDX_W-1:0] idx, input logic d);
    int i;
    // Start on an edge so valid never drops and rises in one step
    @(posedge mclk_i);
    req_valid_i <= 1'h1;
    req_write_i <= wr;
    req_index_i <= idx;
    req_data_i <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk_i);
      if (req_ready_o === 1'h1) break;
    end
    if (i == 40) begin
      failures++;
      final_report();
    end
    req_valid_i <= 1'h0;
  endtask
  task automatic do_read(input logic [IDX_W-1:0] idx, input logic ex);
    int i;
    issue(1'h0, idx, ~ex);
    for (i = 1; i <= 12; i++) begin
      @(posedge mclk_i);
      #1;
      if (rsp_valid_o === 1'h1) break;
    end
    `CHK("read_latency", ACCESS_CYC + 1, i)
    `CHK("read_data", ex, rsp_data_o)
    if (i > 12) final_report();
  endtask
  task automatic t_powerup();
    int i;
    for (i = 0; i < PWR + 10; i++) begin
      @(posedge mclk_i);
      if (req_ready_o === 1'h1) break;
    end
    `CHK("powerup_wait", 1'h1, i >= PWR - 1 && i <= PWR + 1)
    `CHK("mem_ready", 1'h1, mem_ready_o)
  endtask
  // Index extremes and alternating bits, each read twice
  task automatic t_boundary();
    logic [IDX_W-1:0] tbl [4];
    tbl = '{12'h000, 12'hFFF, 12'h555, 12'hAAA};
    for (int k = 0; k < 4; k++) issue(1'h1, tbl[k], k[0] ^ 1'h1);
    for (int k = 0; k < 8; k++) do_read(tbl[k % 4], k[0] ^ 1'h1);
  endtask
  task automatic t_overwrite();
    issue(1'h1, 12'h123, 1'h1);
    do_read(12'h123, 1'h1);
    issue(1'h1, 12'h123, 1'h0);
    do_read(12'h123, 1'h0);
    do_read(12'h000, 1'h1);
  endtask
  // Pin timing watched on every edge
  always @(posedge mclk_i) begin
    if (resetn_i === 1'h1) begin
      if (word_index_o !== idx_q)
        `CHK("index_move_guard", 1'h1, (sel_q | wr_q) & (sel_n_o | wr_n_o))
      if (sel_q === 1'h1 && sel_n_o === 1'h0)
        `CHK("index_at_select", idx_q, word_index_o)
      if (wr_q === 1'h0 && wr_n_o === 1'h1) begin
        `CHK("strobe_low", 1'h1, wlow >= WPULSE_CYC)
        `CHK("select_to_end", 1'h1, slow >= SEL_END_CYC)
      end
      if (wr_n_o === 1'h0) `CHK("write_selected", 1'h0, sel_n_o)
      if (mem_ready_o !== 1'h1) `CHK("idle_in_powerup", 1'h1, sel_n_o)
    end
    wlow = (wr_n_o === 1'h0) ? wlow + 1 : 0;
    slow = (sel_n_o === 1'h0) ? slow + 1 : 0;
    sel_q = sel_n_o;
    wr_q = wr_n_o;
    idx_q = word_index_o;
  end
  initial begin
    resetn_i = 1'h0;
    req_valid_i = 1'h0;
    req_write_i = 1'h0;
    req_index_i = 12'h000;
    req_data_i = 1'h0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'h1;
    t_powerup();
    t_boundary();
    t_overwrite();
    final_report();
  end
endmodule
`default_nettype wire
